// ---- core/sar_link_pkg.sv ----
// constants shared by the converter end and the host end of the serial link
package sar_link_pkg;
    localparam int unsigned RESULT_BITS = 12;
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned LEAD_ZEROS = 3;
    localparam logic [4:0] TRACK_RISE = 5'h0_00D;
    localparam logic [4:0] LAST_FALL = 5'h0_010;
    localparam logic [4:0] MODE_FALL = 5'h0_00A;
    localparam logic [4:0] GUARD_FALL = 5'h0_002;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned SCLK_HALF_NS = 40;
    localparam int unsigned SCLK_HALF_CYC = SCLK_HALF_NS * CLK_MHZ / 1000;
    localparam int unsigned GAP_NS = 40;
    localparam int unsigned GAP_CYC = (GAP_NS * CLK_MHZ + 999) / 1000;
endpackage

// ---- core/sar_link_if.sv ----
// serial link between converter and host
`timescale 1ns/1ns
interface sar_link_if;
    logic frame_sel_n;
    logic sclk;
    logic result_out_o;
    logic result_out_oe;
    logic result_out;
    assign result_out = result_out_oe ? result_out_o : 1'b1;
    modport dev (input frame_sel_n, input sclk, output result_out_o, output result_out_oe);
    modport host (output frame_sel_n, output sclk, input result_out);
endinterface

// ---- core/sar_edge_sync.sv ----
// two-flop synchroniser with edge detection
`timescale 1ns/1ns
module sar_edge_sync (
    input wire logic clock,
    input wire logic srst,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;
    always_ff @(posedge clock) begin
        if (srst) begin
            meta_ff <= 1'b1;
            sync_ff <= 1'b1;
            last_ff <= 1'b1;
        end else begin
            meta_ff <= pin;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end
    assign level = sync_ff;
    assign rise = sync_ff & ~last_ff;
    assign fall = ~sync_ff & last_ff;
endmodule // sar_edge_sync

// ---- core/sar_converter.sv ----
// converter end: frame decode, mode control and serial result shifter
`timescale 1ns/1ns
module sar_converter (
    input wire logic clock,
    input wire logic srst,
    sar_link_if.dev link,
    input wire logic [sar_link_pkg::RESULT_BITS-1:0] analog_code,
    output logic holding,
    output logic shutdown,
    output logic [sar_link_pkg::RESULT_BITS-1:0] held_code
);
    import sar_link_pkg::*;
    logic cs_level;
    logic cs_rise;
    logic cs_fall;
    logic sck_level;
    logic sck_rise;
    logic sck_fall;
    logic [4:0] rise_cnt_ff;
    logic [4:0] fall_cnt_ff;
    logic [FRAME_BITS-1:0] shift_ff;
    logic oe_ff;
    logic dout_ff;
    logic hold_ff;
    logic sdn_ff;
    logic [RESULT_BITS-1:0] code_ff;

    sar_edge_sync u_cs (.clock(clock), .srst(srst), .pin(link.frame_sel_n),
        .level(cs_level), .rise(cs_rise), .fall(cs_fall));
    sar_edge_sync u_sck (.clock(clock), .srst(srst), .pin(link.sclk),
        .level(sck_level), .rise(sck_rise), .fall(sck_fall));

    // edge counters only run inside a frame
    always_ff @(posedge clock) begin
        if (srst || cs_level) begin
            rise_cnt_ff <= 5'h0_000;
            fall_cnt_ff <= 5'h0_000;
        end else begin
            // counters saturate so a runaway link clock cannot wrap them
            if (sck_rise && rise_cnt_ff != 5'h1F)
                rise_cnt_ff <= rise_cnt_ff + 5'h0_001;
            if (sck_fall && fall_cnt_ff != 5'h1F)
                fall_cnt_ff <= fall_cnt_ff + 5'h0_001;
        end
    end

    // sample on select fall, back to track on 13th rise
    always_ff @(posedge clock) begin
        if (srst) begin
            hold_ff <= 1'b0;
            code_ff <= '0;
        end else if (cs_fall) begin
            hold_ff <= 1'b1;
            code_ff <= analog_code;
        end else if (cs_rise || (sck_rise && rise_cnt_ff == TRACK_RISE - 5'h0_001)) begin
            hold_ff <= 1'b0;
        end
    end

    // output shifter: first bit valid at select fall, next bit on falls 1..15, output released on the 16th fall
    always_ff @(posedge clock) begin
        if (srst) begin
            oe_ff <= 1'b0;
            dout_ff <= 1'b0;
            shift_ff <= '0;
        end else if (cs_fall) begin
            oe_ff <= 1'b1;
            dout_ff <= 1'b0;
            shift_ff <= {{LEAD_ZEROS{1'b0}}, analog_code, 1'b0};
        end else if (cs_rise) begin
            oe_ff <= 1'b0;
        end else if (oe_ff && sck_fall) begin
            if (fall_cnt_ff == LAST_FALL - 5'h0_001) begin
                oe_ff <= 1'b0;
            end else begin
                dout_ff <= shift_ff[FRAME_BITS-2];
                shift_ff <= {shift_ff[FRAME_BITS-2:0], 1'b0};
            end
        end
    end

    // mode: low select means normal; early rise (2..9 falls) means shutdown
    always_ff @(posedge clock) begin
        if (srst) begin
            sdn_ff <= 1'b0;
        end else if (cs_fall) begin
            sdn_ff <= 1'b0;
        end else if (cs_rise && fall_cnt_ff >= GUARD_FALL && fall_cnt_ff < MODE_FALL) begin
            sdn_ff <= 1'b1;
        end
    end

    assign link.result_out_o = dout_ff;
    assign link.result_out_oe = oe_ff;
    assign holding = hold_ff;
    assign shutdown = sdn_ff;
    assign held_code = code_ff;
endmodule // sar_converter

// ---- core/sar_host.sv ----
// host end: generates frame select and serial clock, captures the result
`timescale 1ns/1ns
module sar_host (
    input wire logic clock,
    input wire logic srst,
    sar_link_if.host link,
    input wire logic start,
    input wire logic [4:0] stop_after,
    output logic busy,
    output logic done,
    output logic [sar_link_pkg::RESULT_BITS-1:0] result
);
    import sar_link_pkg::*;
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_LOW = 4'b0010,
        S_HIGH = 4'b0100,
        S_GAP = 4'b1000
    } hstate_t;
    hstate_t state_ff;
    logic [7:0] div_ff;
    logic [4:0] falls_ff;
    logic cs_n_ff;
    logic sclk_ff;
    logic [FRAME_BITS-1:0] cap_ff;
    logic done_ff;
    logic [RESULT_BITS-1:0] res_ff;
    logic tick;
    logic meta_ff;
    logic din_ff;
    assign tick = (div_ff == 8'(SCLK_HALF_CYC - 1));

    // data pin sampled through two flops
    always_ff @(posedge clock) begin
        if (srst) begin
            meta_ff <= 1'b0;
            din_ff <= 1'b0;
        end else begin
            meta_ff <= link.result_out;
            din_ff <= meta_ff;
        end
    end

    always_ff @(posedge clock) begin
        if (srst || state_ff == S_IDLE)
            div_ff <= 8'h0_000;
        else if (tick)
            div_ff <= 8'h0_000;
        else
            div_ff <= div_ff + 8'h0_001;
    end

    // sclk idles high; falls count the frame, capture on rises
    always_ff @(posedge clock) begin
        done_ff <= 1'b0;
        if (srst) begin
            state_ff <= S_IDLE;
            cs_n_ff <= 1'b1;
            sclk_ff <= 1'b1;
            falls_ff <= 5'h0_000;
            cap_ff <= '0;
            res_ff <= '0;
        end else begin
            case (state_ff)
                S_IDLE: if (start) begin
                    cs_n_ff <= 1'b0;
                    falls_ff <= 5'h0_000;
                    state_ff <= S_HIGH;
                end
                S_HIGH: if (tick) begin
                    // zero in stop_after asks for a full frame, not an immediate stop
                    if ((stop_after != 5'h0_000 && falls_ff == stop_after)
                            || falls_ff == LAST_FALL) begin
                        cs_n_ff <= 1'b1;
                        state_ff <= S_GAP;
                        // idle-high clock loses the zero shown at select fall, so
                        // rises 3..14 carry the code and the last two are trailing
                        res_ff <= cap_ff[RESULT_BITS+1:2];
                        done_ff <= 1'b1;
                    end else begin
                        sclk_ff <= 1'b0;
                        falls_ff <= falls_ff + 5'h0_001;
                        state_ff <= S_LOW;
                    end
                end
                S_LOW: if (tick) begin
                    sclk_ff <= 1'b1;
                    cap_ff <= {cap_ff[FRAME_BITS-2:0], din_ff};
                    state_ff <= S_HIGH;
                end
                S_GAP: if (tick) begin
                    state_ff <= S_IDLE;
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    assign link.frame_sel_n = cs_n_ff;
    assign link.sclk = sclk_ff;
    assign busy = (state_ff != S_IDLE);
    assign done = done_ff;
    assign result = res_ff;
endmodule // sar_host

// ---- sim/sar_link_asserts.sv ----
// concurrent checks on the serial link between converter and host
`timescale 1ns/1ns
module sar_link_asserts (
    input wire logic clock,
    input wire logic srst,
    input wire logic frame_sel_n,
    input wire logic sclk,
    input wire logic result_out_o,
    input wire logic result_out_oe
);
    logic sclk_ff;
    logic [4:0] fall_cnt_ff;
    always_ff @(posedge clock) begin
        sclk_ff <= sclk;
    end
    // link clock falls seen inside the current frame
    always_ff @(posedge clock) begin
        if (srst || frame_sel_n) begin
            fall_cnt_ff <= 5'h0;
        end else if (sclk_ff && !sclk) begin
            fall_cnt_ff <= fall_cnt_ff + 5'h1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    // converter samples the pins through a synchroniser, hence the slack
    oe_on_a: assert property ($fell(frame_sel_n) |-> ##[1:6] result_out_oe)
        else $error("output not driven after select fall");
    oe_rise_off_a: assert property ($rose(frame_sel_n) |-> ##6 !result_out_oe)
        else $error("output not released after select rise");
    oe_last_off_a: assert property ($fell(sclk) && !frame_sel_n && fall_cnt_ff == 5'hF
        |-> ##6 !result_out_oe) else $error("output not released after last fall");
    idle_off_a: assert property (frame_sel_n [*8] |-> !result_out_oe)
        else $error("output driven while idle");
    lead_zero_a: assert property ($rose(sclk) && !frame_sel_n && fall_cnt_ff < 5'h3
        |-> result_out_oe && !result_out_o) else $error("leading bit not zero");
    data_on_a: assert property ($rose(sclk) && !frame_sel_n && fall_cnt_ff < 5'h10
        |-> result_out_oe) else $error("output released inside frame");
    sclk_high_a: assert property ($rose(sclk) |-> sclk [*8])
        else $error("link clock high phase too short");
    first_fall_a: assert property ($fell(frame_sel_n) |-> sclk [*8])
        else $error("link clock fell too soon after select");
    gap_a: assert property ($rose(frame_sel_n) |-> frame_sel_n [*8])
        else $error("select lowered inside quiet gap");
endmodule // sar_link_asserts

// ---- sim/sar_adc_serial_readout_bench.sv ----
// self-checking bench joining converter and host over the serial link
`timescale 1ns/1ns
module sar_adc_serial_readout_bench;
    import sar_link_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic start = 1'b0;
    logic [4:0] stop_after = 5'h0;
    logic [RESULT_BITS-1:0] analog_code = 12'h0;
    logic holding, shutdown, busy, done;
    logic [RESULT_BITS-1:0] held_code, result;
    int n_errors = 0;
    int compares = 0;
    int q[$];
    int stops[13] = '{0, 16, 1, 5, 16, 16, 12, 16, 2, 9, 10, 15, 16};
    bit sd_model = 1'b0;
    // first frame after power-up or shutdown is a dummy, result unchecked
    bit dummy = 1'b1;
    sar_link_if link();
    sar_converter u_sar_converter (.clock(clock), .srst(srst), .link(link),
        .analog_code(analog_code), .holding(holding), .shutdown(shutdown),
        .held_code(held_code));
    sar_host u_sar_host (.clock(clock), .srst(srst), .link(link), .start(start),
        .stop_after(stop_after), .busy(busy), .done(done), .result(result));
    sar_link_asserts u_sar_link_asserts (.clock(clock), .srst(srst),
        .frame_sel_n(link.frame_sel_n), .sclk(link.sclk),
        .result_out_o(link.result_out_o), .result_out_oe(link.result_out_oe));
    always #2 clock = ~clock;
    task automatic check(input logic [RESULT_BITS-1:0] seen, input logic [RESULT_BITS-1:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic run(input logic [4:0] stop);
        int i;
        int exp;
        i = 0;
        analog_code = 12'($urandom);
        stop_after = stop;
        q.push_back(int'(analog_code));
        start = 1'b1;
        @(posedge clock) #1 start = 1'b0;
        while (done !== 1'b1 && i < 3000) begin
            @(posedge clock) #1 i++;
        end
        exp = q.pop_front();
        if ((stop == 0 || stop >= 16) && !dummy) begin
            check(result, 12'(exp));
            check(held_code, 12'(exp));
            check(12'(holding), 12'h0);
        end
        if (stop >= 2 && stop < 10) begin
            sd_model = 1'b1;
            dummy = 1'b1;
        end else if (stop != 1) begin
            sd_model = 1'b0;
            dummy = 1'b0;
        end
        while (busy !== 1'b0 && i < 3100) begin
            @(posedge clock) #1 i++;
        end
        if (i >= 3000) begin
            n_errors++;
            end_sim();
        end
        // mode must hold across the idle gap until the next select fall
        check(12'(shutdown), 12'(sd_model));
    endtask
    initial begin
        void'($urandom(32'h9a10));
        repeat (8) @(posedge clock);
        #1 srst = 1'b0;
        foreach (stops[k]) run(5'(stops[k]));
        repeat (12) run(5'($urandom_range(0, 20)));
        end_sim();
    end
endmodule // sar_adc_serial_readout_bench
